// ---- hdl/pwr_ctrl_params.svh ----
// Offsets, field positions, reset values and timing counts of pwr_ctrl
`ifndef PWR_CTRL_PARAMS_SVH
`define PWR_CTRL_PARAMS_SVH

`define CLK_PERIOD_NS     10
`define OFF_CMD           12'h000
`define OFF_MON_CFG       12'h004
`define OFF_PWR_STATUS    12'h008
`define OFF_BROWNOUT      12'h00c

`define CMD_SLEEP_BIT     0
`define CMD_DEEP_BIT      1
`define CMD_DOZE_BIT      2
`define CMD_RAM_OFF_BIT   3
`define CMD_OSC_OFF_BIT   4
`define CMD_NVM_OFF_BIT   5
`define CMD_SW_RESET_BIT  6

`define MON_EN_BIT        0
`define MON_LVL_LSB       1
`define MON_RST_EN_BIT    4
`define MON_IRQ_ENTER_BIT 5
`define MON_IRQ_EXIT_BIT  6
`define MON_CFG_RESET     7'h13

`define MON_APPLY_MAX_NS  3300
`define MON_APPLY_CYC     (`MON_APPLY_MAX_NS / `CLK_PERIOD_NS)
`define CHIP_RESET_CYC    16

`endif

// ---- hdl/pwr_ctrl_pkg.sv ----
// Types shared by the power-mode controller
package pwr_ctrl_pkg;

  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,
    ST_DOZE  = 5'b00010,
    ST_SLEEP = 5'b00100,
    ST_DEEP  = 5'b01000,
    ST_RESET = 5'b10000
  } pwr_state_e;

  // Brownout level codes: 1.95,2.0,2.1,2.2,2.3,2.4,2.7,3.0 V
  typedef struct packed {
    logic       irq_exit_en;
    logic       irq_enter_en;
    logic       reset_en;
    logic [2:0] level;
    logic       enable;
  } mon_cfg_s;

  typedef struct packed {
    logic from_deep;
    logic clk32k_ready;
    logic watchdog_cause;
    logic protocol_clk_on;
    logic analog_on;
    logic ram_retained;
    logic wake_done;
  } pwr_status_s;

endpackage

// ---- hdl/pwr_ctrl.sv ----
// Power-mode sequencer, supply monitor control and chip reset source
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "pwr_ctrl_params.svh"
// What this block does
// - In sleep, hold every pin output value and pull-up enable unchanged.
// - Sleep request picks RAM off or on and 32 kHz oscillator off or on.
// - RAM off in sleep means image reload on wake; RAM on keeps contents.
// - Deep sleep powers down CPU, RAM, system and 32 kHz clocks, ext flash.
// - Ordinary sleep keeps external NVM powered unless commanded off before.
// - Sleep ends on pin, comparator or pulse counter interrupt, or on wake timer with the 32 kHz oscillator on.
// - Deep sleep ends only on reset line low or a pin level change.
// - Restart uses cold or warm entry depending on the sleep variant.
// - Doze stops only the CPU clock; all else stays powered and clocked.
// - Any enabled interrupt ends doze and restarts the CPU clock.
// - Readable power status bitmap with seven flags.
// - After reset the monitor is on, at 2.0 V, with brownout reset on.
// - Threshold is one of eight levels; monitor has its own enable bit.
// - Brownout chip reset is individually enabled.
// - Separately enabled interrupts on falling below and rising above.
// - New monitor settings take effect within 3.3 us.
// - Any reset or sleep restores monitor defaults.
// - Readable flag tells whether a brownout caused the last chip reset.
// - While enabled, a readable status shows supply above or below.
// - Software reset runs the full chip reset, like the reset line low.
module pwr_ctrl
  import pwr_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Pins and wake sources
  input  wire logic        external_reset_line_n_in,
  input  wire logic [7:0]  gp_pin_level_in,
  input  wire logic [7:0]  gp_pin_drive_in,
  input  wire logic [7:0]  gp_pin_pullup_in,
  input  wire logic        gp_pin_irq_in,
  input  wire logic        wake_timer_irq_in,
  input  wire logic        comparator_irq_in,
  input  wire logic        pulse_counter_irq_in,
  input  wire logic        any_enabled_irq_in,
  // Analog and status sources
  input  wire logic        supply_below_in,
  input  wire logic        analog_on_in,
  input  wire logic        protocol_clk_on_in,
  input  wire logic        watchdog_cause_in,
  input  wire logic        clk32k_ready_in,
  // Power and clock controls
  output logic [7:0]       gp_pin_drive_out,
  output logic [7:0]       gp_pin_pullup_out,
  output logic             cpu_clk_en_out,
  output logic             core_power_en_out,
  output logic             ram_power_en_out,
  output logic             osc32k_en_out,
  output logic             sys_clk_en_out,
  output logic             ext_nvm_power_en_out,
  output logic             image_reload_out,
  output logic             warm_start_out,
  output logic             chip_reset_out,
  // Supply voltage monitor
  output logic             mon_enable_out,
  output logic [2:0]       mon_level_out,
  output logic             brownout_enter_irq_out,
  output logic             brownout_exit_irq_out
);

  localparam int APPLY_BOUND = `MON_APPLY_CYC;

  pwr_state_e  state_r;
  mon_cfg_s    cfg_r;
  mon_cfg_s    applied_r;
  pwr_status_s status_r;
  logic        ram_off_r;
  logic        osc_off_r;
  logic        nvm_off_req_r;
  logic [7:0]  pin_snap_r;
  logic        below_r;
  logic        bo_cause_r;
  logic [4:0]  rst_cnt_r;
  logic [2:0]  lvl_req_r;
  logic        apb_req;
  logic        apb_wr;
  logic        cmd_wr;
  logic        bo_reset;
  logic        pin_change;
  logic        sleep_wake;
  logic        asleep;

  function automatic logic addr_hit(input logic [11:0] off);
    addr_hit = (paddr_in == off);
  endfunction

  assign apb_req = psel_in & penable_in & ~pready_out;
  assign apb_wr  = psel_in & penable_in & pready_out & pwrite_in;
  assign cmd_wr  = apb_wr & addr_hit(`OFF_CMD) & (state_r == ST_RUN);
  assign bo_reset = applied_r.enable & applied_r.reset_en & below_r;
  assign pin_change = (gp_pin_level_in != pin_snap_r);
  assign sleep_wake = gp_pin_irq_in | comparator_irq_in
                    | pulse_counter_irq_in
                    | (wake_timer_irq_in & ~osc_off_r);
  assign asleep = (state_r == ST_SLEEP) | (state_r == ST_DEEP);

  // APB answers one cycle into the access phase
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end
    else
    begin
      pready_out  <= apb_req;
      pslverr_out <= apb_req & ~(addr_hit(`OFF_CMD) | addr_hit(`OFF_MON_CFG)
                   | addr_hit(`OFF_PWR_STATUS) | addr_hit(`OFF_BROWNOUT));
      prdata_out  <= 32'h0;
      if (apb_req & ~pwrite_in)
      begin
        if (addr_hit(`OFF_MON_CFG))
          prdata_out <= {25'h0, cfg_r};
        else if (addr_hit(`OFF_PWR_STATUS))
          prdata_out <= {25'h0, status_r};
        else if (addr_hit(`OFF_BROWNOUT))
          prdata_out <= {30'h0, bo_cause_r, below_r};
      end
    end
  end

  // Mode sequencer
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_r   <= ST_RESET;
      rst_cnt_r <= 5'h0;
    end
    else
    begin
      case (state_r)
        ST_RUN:
        begin
          rst_cnt_r <= 5'h0;
          if (!external_reset_line_n_in | bo_reset)
            state_r <= ST_RESET;
          else if (cmd_wr & pwdata_in[`CMD_SW_RESET_BIT])
            state_r <= ST_RESET;
          else if (cmd_wr & pwdata_in[`CMD_DEEP_BIT])
            state_r <= ST_DEEP;
          else if (cmd_wr & pwdata_in[`CMD_SLEEP_BIT])
            state_r <= ST_SLEEP;
          else if (cmd_wr & pwdata_in[`CMD_DOZE_BIT])
            state_r <= ST_DOZE;
        end
        ST_DOZE:
          if (!external_reset_line_n_in | bo_reset)
            state_r <= ST_RESET;
          else if (any_enabled_irq_in)
            state_r <= ST_RUN;
        ST_SLEEP:
          if (!external_reset_line_n_in)
            state_r <= ST_RESET;
          else if (sleep_wake)
            state_r <= ST_RUN;
        ST_DEEP:
          if (!external_reset_line_n_in)
            state_r <= ST_RESET;
          else if (pin_change)
            state_r <= ST_RUN;
        ST_RESET:
        begin
          rst_cnt_r <= rst_cnt_r + 5'h1;
          if (rst_cnt_r == 5'(`CHIP_RESET_CYC - 1))
            state_r <= ST_RUN;
        end
        default:
          state_r <= ST_RESET;
      endcase
    end
  end

  // Sleep variant and NVM power-down command are latched at request
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      ram_off_r     <= 1'b0;
      osc_off_r     <= 1'b0;
      nvm_off_req_r <= 1'b0;
      pin_snap_r    <= 8'h0;
    end
    else
    begin
      if (cmd_wr)
      begin
        ram_off_r     <= pwdata_in[`CMD_RAM_OFF_BIT];
        osc_off_r     <= pwdata_in[`CMD_OSC_OFF_BIT];
        nvm_off_req_r <= nvm_off_req_r | pwdata_in[`CMD_NVM_OFF_BIT];
      end
      else if (state_r == ST_RESET)
        nvm_off_req_r <= 1'b0;
      if (state_r == ST_RUN)
        pin_snap_r <= gp_pin_level_in;
    end
  end

  // Pin state frozen while asleep
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      gp_pin_drive_out  <= 8'h0;
      gp_pin_pullup_out <= 8'hff;
    end
    else if (!asleep)
    begin
      gp_pin_drive_out  <= gp_pin_drive_in;
      gp_pin_pullup_out <= gp_pin_pullup_in;
    end
  end

  // Power and clock enables
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      cpu_clk_en_out       <= 1'b0;
      core_power_en_out    <= 1'b1;
      ram_power_en_out     <= 1'b1;
      osc32k_en_out        <= 1'b1;
      sys_clk_en_out       <= 1'b1;
      ext_nvm_power_en_out <= 1'b1;
      chip_reset_out       <= 1'b1;
    end
    else
    begin
      cpu_clk_en_out    <= (state_r == ST_RUN);
      core_power_en_out <= ~asleep;
      ram_power_en_out  <= ~((state_r == ST_DEEP)
                         | ((state_r == ST_SLEEP) & ram_off_r));
      osc32k_en_out     <= ~((state_r == ST_DEEP)
                         | ((state_r == ST_SLEEP) & osc_off_r));
      sys_clk_en_out    <= (state_r != ST_DEEP);
      ext_nvm_power_en_out <= ~((state_r == ST_DEEP)
                            | nvm_off_req_r);
      chip_reset_out    <= (state_r == ST_RESET);
    end
  end

  // Restart entry point and power status
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      warm_start_out   <= 1'b0;
      image_reload_out <= 1'b1;
      status_r         <= '0;
    end
    else
    begin
      status_r.analog_on       <= analog_on_in;
      status_r.protocol_clk_on <= protocol_clk_on_in;
      status_r.clk32k_ready    <= clk32k_ready_in;
      if (state_r == ST_RESET)
      begin
        warm_start_out          <= 1'b0;
        image_reload_out        <= 1'b1;
        status_r.wake_done      <= 1'b0;
        status_r.ram_retained   <= 1'b0;
        status_r.from_deep      <= 1'b0;
        status_r.watchdog_cause <= watchdog_cause_in;
      end
      else if ((state_r == ST_SLEEP) & sleep_wake
               & external_reset_line_n_in)
      begin
        warm_start_out        <= ~ram_off_r;
        image_reload_out      <= ram_off_r;
        status_r.wake_done    <= 1'b1;
        status_r.ram_retained <= ~ram_off_r;
        status_r.from_deep    <= 1'b0;
      end
      else if ((state_r == ST_DEEP) & pin_change
               & external_reset_line_n_in)
      begin
        warm_start_out        <= 1'b0;
        image_reload_out      <= 1'b1;
        status_r.wake_done    <= 1'b1;
        status_r.ram_retained <= 1'b0;
        status_r.from_deep    <= 1'b1;
      end
    end
  end

  // Monitor settings; defaults return on reset and on every sleep
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      cfg_r     <= mon_cfg_s'(`MON_CFG_RESET);
      applied_r <= mon_cfg_s'(`MON_CFG_RESET);
      lvl_req_r <= 3'h1;
    end
    else
    begin
      if ((state_r == ST_RESET) | asleep)
        cfg_r <= mon_cfg_s'(`MON_CFG_RESET);
      else if (apb_wr & addr_hit(`OFF_MON_CFG))
        cfg_r <= mon_cfg_s'(pwdata_in[6:0]);
      applied_r <= cfg_r;
      // Level last written, kept for the apply-time check
      if (apb_wr & addr_hit(`OFF_MON_CFG))
        lvl_req_r <= pwdata_in[3:1];
    end
  end

  // Below-threshold level, brownout events and reset cause
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      below_r                <= 1'b0;
      bo_cause_r             <= 1'b0;
      brownout_enter_irq_out <= 1'b0;
      brownout_exit_irq_out  <= 1'b0;
      mon_enable_out         <= 1'b1;
      mon_level_out          <= 3'h1;
    end
    else
    begin
      mon_enable_out <= applied_r.enable;
      mon_level_out  <= applied_r.level;
      below_r <= applied_r.enable & supply_below_in;
      brownout_enter_irq_out <= applied_r.irq_enter_en
                              & applied_r.enable
                              & supply_below_in & ~below_r;
      brownout_exit_irq_out  <= applied_r.irq_exit_en
                              & applied_r.enable
                              & ~supply_below_in & below_r;
      if ((state_r != ST_RESET) & bo_reset)
        bo_cause_r <= 1'b1;
      else if ((state_r != ST_RESET) & ~external_reset_line_n_in)
        bo_cause_r <= 1'b0;
      else if (cmd_wr & pwdata_in[`CMD_SW_RESET_BIT])
        bo_cause_r <= 1'b0;
    end
  end

  a_pin_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    asleep ##1 asleep |-> $stable(gp_pin_drive_out)
      && $stable(gp_pin_pullup_out))
    else $error("pin state moved during sleep");

  a_deep_power: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_r == ST_DEEP |=> !ram_power_en_out && !osc32k_en_out
      && !sys_clk_en_out && !ext_nvm_power_en_out)
    else $error("deep sleep left a domain powered");

  a_sleep_nvm: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_r == ST_SLEEP && !nvm_off_req_r |=> ext_nvm_power_en_out)
    else $error("external memory lost power in sleep");

  a_doze_only_cpu: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_r == ST_DOZE |=> !cpu_clk_en_out && core_power_en_out
      && ram_power_en_out && sys_clk_en_out)
    else $error("doze gated more than the cpu clock");

  a_doze_wake: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_r == ST_DOZE && any_enabled_irq_in && external_reset_line_n_in
      && !bo_reset |-> ##2 cpu_clk_en_out)
    else $error("interrupt did not end doze");

  a_deep_stays: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_r == ST_DEEP && external_reset_line_n_in && !pin_change
      |=> state_r == ST_DEEP)
    else $error("deep sleep left without cause");

  a_warm_entry: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_r == ST_SLEEP && sleep_wake && external_reset_line_n_in
      |=> warm_start_out == !ram_off_r
        && image_reload_out == ram_off_r)
    else $error("wrong restart entry after sleep");

  a_cfg_apply: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    apb_wr && addr_hit(`OFF_MON_CFG) && state_r == ST_RUN
      |-> ##[1:APPLY_BOUND] mon_level_out == lvl_req_r)
    else $error("monitor level not applied in time");

  a_sleep_default: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    asleep |=> cfg_r == mon_cfg_s'(`MON_CFG_RESET))
    else $error("monitor defaults not restored");

  a_bo_reset: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_r == ST_RUN && bo_reset |-> ##2 chip_reset_out && bo_cause_r)
    else $error("brownout did not reset the chip");

  a_sw_reset: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    cmd_wr && pwdata_in[`CMD_SW_RESET_BIT] && external_reset_line_n_in
      && !bo_reset |-> ##2 chip_reset_out [*8])
    else $error("software reset too short");

  a_enter_irq: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    brownout_enter_irq_out |-> below_r && $past(applied_r.irq_enter_en))
    else $error("enter interrupt without cause");

endmodule

// ---- testbench/wake_partner.sv ----
// Model of the external reset line and the pin levels seen by the block
`timescale 1ns/100ps
module wake_partner
#(
  parameter int RST_LOW_CYC = 4
)
(
  // Clock
  input  wire logic       clk_in,
  // Requests from the bench
  input  wire logic       reset_pulse_in,
  input  wire logic [7:0] pin_flip_in,
  // Lines to the block
  output logic            reset_line_n_out,
  output logic [7:0]      pin_level_out
);
  logic [3:0] low_cnt_r = 4'h0;
  logic [7:0] level_r   = 8'h5a;

  // Line has a pull-up, so it reads high once released
  always_ff @(posedge clk_in)
  begin
    if (reset_pulse_in)
      low_cnt_r <= 4'(RST_LOW_CYC);
    else if (low_cnt_r != 4'h0)
      low_cnt_r <= low_cnt_r - 4'h1;
  end

  always_ff @(posedge clk_in)
  begin
    level_r <= level_r ^ pin_flip_in;
  end

  assign reset_line_n_out = (low_cnt_r == 4'h0);
  assign pin_level_out    = level_r;
endmodule

// ---- testbench/test_pwr_ctrl.sv ----
// Self-checking bench for the power-mode controller
`timescale 1ns/100ps
`include "pwr_ctrl_params.svh"
module test_pwr_ctrl
  import pwr_ctrl_pkg::*;
;
  typedef struct packed
  {
    logic        err;
    logic [31:0] mask;
    logic [31:0] data;
  } note_s;
  logic        clk, rst_n, psel, penable, pwrite, below, any_irq, rst_req;
  logic        ready, slverr, ext_n, cpu_en, core_en, ram_en, osc_en;
  logic        sclk_en, nvm_en, reload, warm, chip_rst, mon_en;
  logic        enter_irq, exit_irq;
  logic [2:0]  lvl, lvl_exp;
  logic [3:0]  wk, src;
  logic [7:0]  drv, pup, flip, pins, drv_o, pup_o, hold;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] rnd;
  note_s       q[$];
  note_s       e;
  int          error_cnt;
  int          samples_checked;

  wake_partner peer (.clk_in(clk), .reset_pulse_in(rst_req),
    .pin_flip_in(flip), .reset_line_n_out(ext_n), .pin_level_out(pins));

  pwr_ctrl DUT (.sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(ready),
    .pslverr_out(slverr), .external_reset_line_n_in(ext_n),
    .gp_pin_level_in(pins), .gp_pin_drive_in(drv),
    .gp_pin_pullup_in(pup), .gp_pin_irq_in(wk[0]),
    .wake_timer_irq_in(wk[1]), .comparator_irq_in(wk[2]),
    .pulse_counter_irq_in(wk[3]), .any_enabled_irq_in(any_irq),
    .supply_below_in(below), .analog_on_in(src[0]),
    .protocol_clk_on_in(src[1]), .watchdog_cause_in(src[2]),
    .clk32k_ready_in(src[3]), .gp_pin_drive_out(drv_o),
    .gp_pin_pullup_out(pup_o), .cpu_clk_en_out(cpu_en),
    .core_power_en_out(core_en), .ram_power_en_out(ram_en),
    .osc32k_en_out(osc_en), .sys_clk_en_out(sclk_en),
    .ext_nvm_power_en_out(nvm_en), .image_reload_out(reload),
    .warm_start_out(warm), .chip_reset_out(chip_rst),
    .mon_enable_out(mon_en), .mon_level_out(lvl),
    .brownout_enter_irq_out(enter_irq), .brownout_exit_irq_out(exit_irq));

  always #5 clk = ~clk;

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {1'b0, x[15:1]} ^ (x[0] ? 16'hb400 : 16'h0000);
  endfunction

  function automatic logic sig(input int s);
    case (s)
      0: sig = core_en;
      1: sig = cpu_en;
      2: sig = chip_rst;
      3: sig = enter_irq;
      4: sig = exit_irq;
      default: sig = (lvl === lvl_exp);
    endcase
  endfunction

  task automatic check(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Bounded wait; running out shows up as a mismatch
  task automatic wait_sig(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(s) !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    check("wait", 32'(sig(s)), 32'(v));
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a stalled access
    do
    begin
      @(posedge clk);
    end
    while (ready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    q.push_back('{1'b0, 32'h0, 32'h0});
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m, x,
                    input logic er = 1'b0);
    q.push_back('{er, m, x});
    apb(1'b0, a, 32'h0);
  endtask

  // Each answer is judged against the oldest note
  always @(posedge clk)
  begin
    if (ready === 1'b1)
    begin
      e = q.pop_front();
      check("prdata", prdata & e.mask, e.data & e.mask);
      check("pslverr", 32'(slverr), 32'(e.err));
    end
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial
  begin
    {clk, rst_n, psel, penable, pwrite, below, any_irq, rst_req} = 8'h00;
    {wk, src, flip, paddr, pwdata, lvl_exp} = '0;
    {drv, pup} = 16'h0000;
    rnd = 16'hd8c3;
    error_cnt = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wait_sig(1, 1'b1, 40);
    check("mon_en", 32'(mon_en), 32'h1);
    check("mon_lvl", 32'(lvl), 32'h1);
    rd(`OFF_MON_CFG, 32'h7f, 32'(`MON_CFG_RESET));
    rd(12'h010, 32'hffffffff, 32'h0, 1'b1);
    rnd = lfsr(rnd);
    src <= rnd[3:0];
    repeat (2) @(posedge clk);
    // Watchdog cause is latched only during chip reset
    rd(`OFF_PWR_STATUS, 32'h3c,
       {26'h0, src[3], 1'b0, src[1:0], 2'h0});
    for (int i = 0; i < 8; i++)
    begin
      lvl_exp = 3'(i);
      wr(`OFF_MON_CFG, {28'h0, lvl_exp, 1'b1});
      wait_sig(5, 1'b1, 330);
      rd(`OFF_MON_CFG, 32'h7f, {28'h0, lvl_exp, 1'b1});
    end
    wr(`OFF_MON_CFG, 32'h63);
    below <= 1'b1;
    wait_sig(3, 1'b1, 10);
    rd(`OFF_BROWNOUT, 32'h1, 32'h1);
    check("no_bo_rst", 32'(chip_rst), 32'h0);
    below <= 1'b0;
    wait_sig(4, 1'b1, 10);
    rd(`OFF_BROWNOUT, 32'h1, 32'h0);
    wr(`OFF_MON_CFG, 32'h62);
    below <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`OFF_BROWNOUT, 32'h1, 32'h0);
    below <= 1'b0;
    wr(`OFF_CMD, 32'h04);
    wait_sig(1, 1'b0, 10);
    check("doze", {28'h0, sclk_en, core_en, ram_en, osc_en}, 32'hf);
    any_irq <= 1'b1;
    wait_sig(1, 1'b1, 10);
    any_irq <= 1'b0;
    // Timer wake only with the oscillator kept running
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      drv <= rnd[7:0];
      pup <= rnd[15:8];
      wr(`OFF_MON_CFG, 32'h60);
      wr(`OFF_CMD, {27'h0, i[1], i[0], 3'b001});
      wait_sig(0, 1'b0, 10);
      hold = drv_o;
      drv <= ~drv;
      pup <= ~pup;
      repeat (3) @(posedge clk);
      check("pin_drv", {24'h0, drv_o}, {24'h0, hold});
      check("pin_pup", {24'h0, pup_o}, {24'h0, ~pup});
      check("ram_pwr", 32'(ram_en), 32'(!i[0]));
      check("osc_pwr", 32'(osc_en), 32'(!i[1]));
      check("nvm_pwr", 32'(nvm_en), 32'h1);
      // A timer event must not wake the chip with the oscillator off
      if (i[1])
      begin
        wk <= 4'h2;
        repeat (4) @(posedge clk);
        check("timer_off", 32'(core_en), 32'h0);
      end
      wk <= 4'(1 << i);
      wait_sig(0, 1'b1, 10);
      wk <= 4'h0;
      wait_sig(1, 1'b1, 10);
      check("reload", 32'(reload), 32'(i[0]));
      check("warm", 32'(warm), 32'(!i[0]));
      rd(`OFF_PWR_STATUS, 32'h3, {30'h0, !i[0], 1'b1});
      rd(`OFF_MON_CFG, 32'h7f, 32'(`MON_CFG_RESET));
    end
    wr(`OFF_CMD, 32'h02);
    wait_sig(0, 1'b0, 10);
    check("deep", {28'h0, ram_en, osc_en, sclk_en, nvm_en}, 32'h0);
    wk <= 4'hf;
    repeat (20) @(posedge clk);
    check("deep_hold", 32'(core_en), 32'h0);
    wk <= 4'h0;
    flip <= 8'h01;
    @(posedge clk);
    flip <= 8'h00;
    wait_sig(1, 1'b1, 60);
    check("cold", 32'(reload), 32'h1);
    rd(`OFF_PWR_STATUS, 32'h40, 32'h40);
    wr(`OFF_CMD, 32'h02);
    wait_sig(0, 1'b0, 10);
    rst_req <= 1'b1;
    @(posedge clk);
    rst_req <= 1'b0;
    wait_sig(2, 1'b1, 20);
    wait_sig(1, 1'b1, 60);
    wr(`OFF_CMD, 32'h20);
    repeat (3) @(posedge clk);
    check("nvm_off", 32'(nvm_en), 32'h0);
    below <= 1'b1;
    wait_sig(2, 1'b1, 10);
    below <= 1'b0;
    wait_sig(1, 1'b1, 60);
    check("nvm_back", 32'(nvm_en), 32'h1);
    rd(`OFF_BROWNOUT, 32'h2, 32'h2);
    rd(`OFF_MON_CFG, 32'h7f, 32'(`MON_CFG_RESET));
    src <= 4'h4;
    wr(`OFF_CMD, 32'h40);
    wait_sig(2, 1'b1, 10);
    wait_sig(1, 1'b1, 60);
    rd(`OFF_BROWNOUT, 32'h2, 32'h0);
    rd(`OFF_PWR_STATUS, 32'h10, 32'h10);
    repeat (4) @(posedge clk);
    results();
  end
endmodule
